// ---- verilog/cq_cfg_pkg.sv ----
// Register map, field positions and timing constants for the C/Q configuration block
package cq_cfg_pkg;
  // Printed offsets are not all multiples of four: they are indices, byte address is index times four
  localparam logic [7:0] line_state_cfg_b_idx = 8'h1B;
  localparam logic [7:0] drv_limit_cfg_idx = 8'h1C;
  localparam logic [7:0] drv_status_idx = 8'h20;
  localparam logic [7:0] pin_ctrl_idx = 8'h21;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // Line-state register field positions
  localparam int aux_level_bit = 7;
  localparam int line_level_bit = 6;
  localparam int soft_en_bit = 5;
  localparam int soft_data_bit = 4;
  localparam int filter_bit = 3;
  localparam int thresh_bit = 2;
  localparam int source_bit = 1;
  localparam int sink_bit = 0;
  // Driver limit register field positions
  localparam int limit_hi = 7;
  localparam int limit_lo = 6;
  localparam int limit_off_bit = 5;
  localparam int blank_hi = 4;
  localparam int blank_lo = 3;
  localparam int retry_hi = 2;
  localparam int retry_lo = 1;
  localparam int retry_en_bit = 0;
  // Clock rate and times in their own units
  localparam int clk_mhz = 100;
  localparam int blank0_us = 128;
  localparam int blank1_us = 500;
  localparam int blank2_us = 1000;
  localparam int blank3_us = 5000;
  localparam int retry0_ms = 50;
  localparam int retry1_ms = 100;
  localparam int retry2_ms = 200;
  localparam int retry3_ms = 500;
  // Cycle counts derived from the rate
  localparam int blank0_cyc = blank0_us * clk_mhz;
  localparam int blank1_cyc = blank1_us * clk_mhz;
  localparam int blank2_cyc = blank2_us * clk_mhz;
  localparam int blank3_cyc = blank3_us * clk_mhz;
  localparam int retry0_cyc = retry0_ms * 1000 * clk_mhz;
  localparam int retry1_cyc = retry1_ms * 1000 * clk_mhz;
  localparam int retry2_cyc = retry2_ms * 1000 * clk_mhz;
  localparam int retry3_cyc = retry3_ms * 1000 * clk_mhz;
  localparam int cnt_w = 26;
  // Driver protection states
  typedef enum logic [1:0] {
    drv_on = 2'b00,
    drv_blank = 2'b01,
    drv_off = 2'b10,
    drv_latched = 2'b11
  } drv_state_t;
endpackage

// ---- verilog/cq_driver_guard.sv ----
// One C/Q driver's overcurrent blanking, fault flag and autoretry sequencer
`timescale 1ns/1ps
module cq_driver_guard (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic overcurrent, // Synchronised overcurrent level
  input wire logic [cq_cfg_pkg::cnt_w-1:0] blank_cyc,
  input wire logic [cq_cfg_pkg::cnt_w-1:0] retry_cyc,
  input wire logic retry_en,
  output logic allow_q, // Driver may be enabled
  output logic fault_q // Fault indication
);
  cq_cfg_pkg::drv_state_t state_q, state_d;
  logic [cq_cfg_pkg::cnt_w-1:0] cnt_q, cnt_d;
  logic fault_d;
  logic blank_done;
  logic retry_done;

  assign blank_done = (cnt_q >= blank_cyc - 1'b1);
  assign retry_done = (cnt_q >= retry_cyc - 1'b1);

  // Next-state logic: overcurrent must outlast blanking before a fault
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    fault_d = fault_q;
    case (state_q)
      cq_cfg_pkg::drv_on: begin
        cnt_d = '0;
        // Fault gone: clear indication, normal operation
        if (!overcurrent) begin
          fault_d = 1'b0;
        end else begin
          state_d = cq_cfg_pkg::drv_blank;
        end
      end
      cq_cfg_pkg::drv_blank: begin
        if (!overcurrent && !fault_q) begin
          // Short transient before any fault: back to normal at once
          state_d = cq_cfg_pkg::drv_on;
          cnt_d = '0;
        end else if (blank_done) begin
          // After a retry the sensed level lags the re-enabled driver, so decide only here
          cnt_d = '0;
          if (overcurrent) begin
            // Persisting fault stays flagged and the driver goes off again
            fault_d = 1'b1;
            state_d = retry_en ? cq_cfg_pkg::drv_off : cq_cfg_pkg::drv_latched;
          end else begin
            // Recheck found the fault gone
            fault_d = 1'b0;
            state_d = cq_cfg_pkg::drv_on;
          end
        end
      end
      cq_cfg_pkg::drv_off: begin
        // Off for the retry timeout, then re-enabled and rechecked
        if (retry_done) begin
          state_d = cq_cfg_pkg::drv_blank;
          cnt_d = '0;
        end
      end
      cq_cfg_pkg::drv_latched: begin
        // Without retry the driver stays off until retry is enabled
        cnt_d = '0;
        if (retry_en) begin
          state_d = cq_cfg_pkg::drv_off;
        end
      end
      default: begin
        state_d = cq_cfg_pkg::drv_on;
        cnt_d = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cq_cfg_pkg::drv_on;
      cnt_q <= '0;
      fault_q <= 1'b0;
      allow_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      fault_q <= fault_d;
      allow_q <= (state_d == cq_cfg_pkg::drv_on) || (state_d == cq_cfg_pkg::drv_blank);
    end
  end
endmodule

// ---- verilog/cq_driver_fault_and_input_cfg.sv ----
// AXI4-Lite register bank for channel B line state and shared C/Q driver protection
// Functional notes
// - Bit 7 reports auxiliary input B level
// - Bit 6 reports line B level
// - Bit 5 is transmit enable under software control
// - Bit 4 is transmit data under software control
// - Bit 3 enables auxiliary input glitch filter
// - Bit 2 selects type 2/3 thresholds
// - Bit 1 turns on input current source
// - Bit 0 turns on input current sink
// - Limit field selects 100/200/300/500 mA
// - Limit-off bit disables current limiting
// - Blanking field sets fault qualification time
// - Retry field sets faulted driver off time
// - Faulted driver off for timeout, then on
// - Retry-enable bit enables automatic retry
// - After retry and blanking, recheck fault
// - Fault gone clears flag, normal operation
// - Software pin control overrides external pins
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module cq_driver_fault_and_input_cfg (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line-side inputs from pins
  input wire logic aux_input_b_pin, // Auxiliary digital input level
  input wire logic line_b_sense, // C/Q line B level
  input wire logic transmit_enable_pin_b,
  input wire logic transmit_data_pin_b,
  input wire logic line_a_overcurrent,
  input wire logic line_b_overcurrent,
  // Line-side controls
  output logic line_a_driver_allow,
  output logic line_b_driver_enable,
  output logic line_b_driver_data,
  output logic [1:0] driver_limit_level,
  output logic driver_limit_off,
  output logic aux_input_b_glitch_filter_on,
  output logic aux_input_b_threshold_type,
  output logic aux_input_b_source_on,
  output logic aux_input_b_sink_on
);
  localparam int n_in = 6;

  // Two-stage synchronisers for all pin inputs
  logic [n_in-1:0] pin_raw;
  logic [n_in-1:0] sync1_q;
  logic [n_in-1:0] sync2_q;
  assign pin_raw = {line_b_overcurrent, line_a_overcurrent, transmit_data_pin_b,
                    transmit_enable_pin_b, line_b_sense, aux_input_b_pin};

  genvar gi;
  generate
    for (gi = 0; gi < n_in; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic aux_level;
  logic line_level;
  logic pin_en;
  logic pin_data;
  logic oc_a;
  logic oc_b;
  assign aux_level = sync2_q[0];
  assign line_level = sync2_q[1];
  assign pin_en = sync2_q[2];
  assign pin_data = sync2_q[3];
  assign oc_a = sync2_q[4];
  assign oc_b = sync2_q[5];

  // Stored register bits
  logic [5:0] line_cfg_q; // Writable low six bits of the line-state register
  logic [7:0] limit_cfg_q; // Driver limit register
  logic soft_pins_q; // Software pin control select

  // Address decode from word index
  function automatic logic [7:0] word_idx(input logic [9:0] addr);
    return addr[9:2];
  endfunction

  // Blanking count from field
  function automatic logic [cq_cfg_pkg::cnt_w-1:0] blank_sel(input logic [1:0] f);
    case (f)
      2'h0: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::blank0_cyc);
      2'h1: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::blank1_cyc);
      2'h2: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::blank2_cyc);
      default: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::blank3_cyc);
    endcase
  endfunction

  // Retry off-time count from field
  function automatic logic [cq_cfg_pkg::cnt_w-1:0] retry_sel(input logic [1:0] f);
    case (f)
      2'h0: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::retry0_cyc);
      2'h1: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::retry1_cyc);
      2'h2: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::retry2_cyc);
      default: return cq_cfg_pkg::cnt_w'(cq_cfg_pkg::retry3_cyc);
    endcase
  endfunction

  logic [cq_cfg_pkg::cnt_w-1:0] blank_cyc;
  logic [cq_cfg_pkg::cnt_w-1:0] retry_cyc;
  assign blank_cyc = blank_sel(limit_cfg_q[cq_cfg_pkg::blank_hi:cq_cfg_pkg::blank_lo]);
  assign retry_cyc = retry_sel(limit_cfg_q[cq_cfg_pkg::retry_hi:cq_cfg_pkg::retry_lo]);

  // One protection sequencer per driver; both share the settings
  logic allow_a;
  logic allow_b;
  logic fault_a;
  logic fault_b;
  cq_driver_guard u_guard_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .overcurrent(oc_a),
    .blank_cyc(blank_cyc),
    .retry_cyc(retry_cyc),
    .retry_en(limit_cfg_q[cq_cfg_pkg::retry_en_bit]),
    .allow_q(allow_a),
    .fault_q(fault_a)
  );
  cq_driver_guard u_guard_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .overcurrent(oc_b),
    .blank_cyc(blank_cyc),
    .retry_cyc(retry_cyc),
    .retry_en(limit_cfg_q[cq_cfg_pkg::retry_en_bit]),
    .allow_q(allow_b),
    .fault_q(fault_b)
  );

  // Write channel: address and data accepted in either order
  logic aw_held_q;
  logic w_held_q;
  logic [9:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_hit;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = word_idx(awaddr_q);
  assign wr_hit = (wr_idx == cq_cfg_pkg::line_state_cfg_b_idx) ||
                  (wr_idx == cq_cfg_pkg::drv_limit_cfg_idx) ||
                  (wr_idx == cq_cfg_pkg::drv_status_idx) ||
                  (wr_idx == cq_cfg_pkg::pin_ctrl_idx);

  // Write handshake and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cq_cfg_pkg::resp_okay;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer with a slave error
        s_axi_bresp <= wr_hit ? cq_cfg_pkg::resp_okay : cq_cfg_pkg::resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready stays low while a word is held, giving one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !w_held_q && !w_take && !s_axi_bvalid && !wr_fire;
    end
  end

  // Register storage; only byte lane 0 carries data
  logic wr_lane0;
  assign wr_lane0 = wr_fire && wstrb_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_cfg_q <= '0;
      limit_cfg_q <= cq_cfg_pkg::reset_byte;
      soft_pins_q <= 1'b0;
    end else if (wr_lane0) begin
      if (wr_idx == cq_cfg_pkg::line_state_cfg_b_idx) begin
        // Level bits 7:6 are read-only and not stored
        line_cfg_q <= wdata_q[cq_cfg_pkg::soft_en_bit:cq_cfg_pkg::sink_bit];
      end
      if (wr_idx == cq_cfg_pkg::drv_limit_cfg_idx) begin
        limit_cfg_q <= wdata_q[7:0];
      end
      if (wr_idx == cq_cfg_pkg::pin_ctrl_idx) begin
        soft_pins_q <= wdata_q[0];
      end
    end
  end

  // Read data mux; reads have no side effects
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] line_state_view;
  assign rd_idx = word_idx(s_axi_araddr);
  assign line_state_view = {aux_level, line_level, line_cfg_q};
  assign rd_hit = (rd_idx == cq_cfg_pkg::line_state_cfg_b_idx) ||
                  (rd_idx == cq_cfg_pkg::drv_limit_cfg_idx) ||
                  (rd_idx == cq_cfg_pkg::drv_status_idx) ||
                  (rd_idx == cq_cfg_pkg::pin_ctrl_idx);
  assign rd_byte = (rd_idx == cq_cfg_pkg::line_state_cfg_b_idx) ? line_state_view :
                   (rd_idx == cq_cfg_pkg::drv_limit_cfg_idx) ? limit_cfg_q :
                   (rd_idx == cq_cfg_pkg::drv_status_idx) ? {6'h00, fault_b, fault_a} :
                   (rd_idx == cq_cfg_pkg::pin_ctrl_idx) ? {7'h00, soft_pins_q} : 8'h00;

  // Read channel: one read at a time, data registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cq_cfg_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? cq_cfg_pkg::resp_okay : cq_cfg_pkg::resp_slverr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Transmit source selection: register bits replace the pins under software control
  logic tx_en_sel;
  logic tx_data_sel;
  assign tx_en_sel = soft_pins_q ? line_cfg_q[cq_cfg_pkg::soft_en_bit] : pin_en;
  assign tx_data_sel = soft_pins_q ? line_cfg_q[cq_cfg_pkg::soft_data_bit] : pin_data;

  // Registered line-side controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_a_driver_allow <= 1'b0;
      line_b_driver_enable <= 1'b0;
      line_b_driver_data <= 1'b0;
      driver_limit_level <= 2'h0;
      driver_limit_off <= 1'b0;
      aux_input_b_glitch_filter_on <= 1'b0;
      aux_input_b_threshold_type <= 1'b0;
      aux_input_b_source_on <= 1'b0;
      aux_input_b_sink_on <= 1'b0;
    end else begin
      line_a_driver_allow <= allow_a;
      // Driver B is held off while its guard is in drv_off or drv_latched, regardless of the transmit request
      line_b_driver_enable <= tx_en_sel && allow_b;
      line_b_driver_data <= tx_data_sel;
      driver_limit_level <= limit_cfg_q[cq_cfg_pkg::limit_hi:cq_cfg_pkg::limit_lo];
      driver_limit_off <= limit_cfg_q[cq_cfg_pkg::limit_off_bit];
      aux_input_b_glitch_filter_on <= line_cfg_q[cq_cfg_pkg::filter_bit];
      aux_input_b_threshold_type <= line_cfg_q[cq_cfg_pkg::thresh_bit];
      aux_input_b_source_on <= line_cfg_q[cq_cfg_pkg::source_bit];
      aux_input_b_sink_on <= line_cfg_q[cq_cfg_pkg::sink_bit];
    end
  end
endmodule

// ---- verification/line_side_model.sv ----
// Behavioural line-side load: C/Q line level and driver overcurrent
`timescale 1ns/1ps
module line_side_model (
  input wire logic line_b_driver_enable,
  input wire logic line_b_driver_data,
  input wire logic line_a_driver_allow,
  input wire logic short_a,
  input wire logic short_b,
  output logic line_b_sense,
  output logic line_a_overcurrent,
  output logic line_b_overcurrent
);
  // Released line is pulled to ground by the load, so it never holds its last level
  assign line_b_sense = line_b_driver_enable & line_b_driver_data;
  // A short only draws current while the driver is on, as a real load would
  assign line_a_overcurrent = short_a & line_a_driver_allow;
  assign line_b_overcurrent = short_b & line_b_driver_enable;
endmodule

// ---- verification/cq_cfg_checks_asserts.sv ----
// Port-level concurrent checks for the C/Q configuration block
`timescale 1ns/1ps
module cq_cfg_checks (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_a_overcurrent,
  input wire logic line_a_driver_allow,
  input wire logic [1:0] driver_limit_level,
  input wire logic driver_limit_off,
  input wire logic aux_input_b_glitch_filter_on,
  input wire logic aux_input_b_threshold_type,
  input wire logic aux_input_b_source_on,
  input wire logic aux_input_b_sink_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Overcurrent run length on driver A; saturates so a long short never wraps
  logic [15:0] oc_run_q;
  logic [15:0] oc_run_d;
  assign oc_run_d = !line_a_overcurrent ? 16'h0000 : (&oc_run_q ? oc_run_q : oc_run_q + 16'h0001);
  // Run counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_run_q <= 16'h0000;
    end else begin
      oc_run_q <= oc_run_d;
    end
  end
  // Limit, filter and sink outputs change, threshold type rises and source falls only around a write response
  AST_LIMIT_LEVEL: assert property ($changed(driver_limit_level) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("limit level moved without write");
  AST_LIMIT_OFF: assert property ($changed(driver_limit_off) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("limit off moved without write");
  AST_FILTER: assert property ($changed(aux_input_b_glitch_filter_on) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("filter moved without write");
  AST_THRESH: assert property ($rose(aux_input_b_threshold_type) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("threshold rose without write");
  AST_SOURCE: assert property ($fell(aux_input_b_source_on) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("source fell without write");
  AST_SINK: assert property ($changed(aux_input_b_sink_on) |-> $past(s_axi_bvalid, 1) || s_axi_bvalid) else $error("sink moved without write");
  // Driver A is cut only after the shortest blanking span of overcurrent
  AST_BLANK_MIN: assert property ($fell(line_a_driver_allow) |-> oc_run_q >= cq_cfg_pkg::blank0_cyc) else $error("driver cut before blanking");
  AST_READY_AFTER_RESET: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_arready && line_a_driver_allow) else $error("not ready after reset");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  // Main scenarios
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_FAULT: cover property ($fell(line_a_driver_allow));
endmodule
bind cq_driver_fault_and_input_cfg cq_cfg_checks chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .line_a_overcurrent, .line_a_driver_allow, .driver_limit_level, .driver_limit_off, .aux_input_b_glitch_filter_on, .aux_input_b_threshold_type, .aux_input_b_source_on, .aux_input_b_sink_on);

// ---- verification/test_cq_driver_fault_and_input_cfg.sv ----
// Self-checking bench for the C/Q configuration register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin fail_count++; $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module test_cq_driver_fault_and_input_cfg;
  localparam logic [9:0] ls_a = {cq_cfg_pkg::line_state_cfg_b_idx, 2'b00};
  localparam logic [9:0] lim_a = {cq_cfg_pkg::drv_limit_cfg_idx, 2'b00};
  localparam logic [9:0] pc_a = {cq_cfg_pkg::pin_ctrl_idx, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [9:0] s_axi_araddr = 10'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic aux_input_b_pin = 1'b0;
  logic transmit_enable_pin_b = 1'b0;
  logic transmit_data_pin_b = 1'b0;
  logic short_a = 1'b0;
  logic short_b = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, driver_limit_level, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic line_b_sense, line_a_overcurrent, line_b_overcurrent, line_a_driver_allow;
  logic line_b_driver_enable, line_b_driver_data, driver_limit_off, en, dt;
  logic aux_input_b_glitch_filter_on, aux_input_b_threshold_type;
  logic aux_input_b_source_on, aux_input_b_sink_on;
  logic [7:0] d;
  logic [4:0] b;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  cq_driver_fault_and_input_cfg dut_u (.*);
  line_side_model part_u (.*);
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  // Verdict and end of run
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Write low byte; address and data offered together, bready held until the answer
  task automatic axw(input logic [9:0] a, input logic [7:0] v, input logic [3:0] s);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_bready && k < 200);
    `CHK("write wait", 1'b1, k < 200)
  endtask
  // Read one word; rready rises once rvalid is seen, so read data must hold a cycle
  task automatic axr(input logic [9:0] a);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        got = 1'b1;
      end else if (s_axi_rvalid) begin
        s_axi_rready <= 1'b1;
      end
    end while (!got && k < 200);
    `CHK("read wait", 1'b1, got)
  endtask
  // Read and compare a register
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    axr(a);
    `CHK("read data", {24'h000000, e}, rd)
    `CHK("read resp", cq_cfg_pkg::resp_okay, rsp)
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #700000;
    fail_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(39));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(ls_a, cq_cfg_pkg::reset_byte);
    rdchk(lim_a, cq_cfg_pkg::reset_byte);
    // Random field values; the driver stays off so line level reads low
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      axw(lim_a, d, 4'hF);
      rdchk(lim_a, d);
      `CHK("limit level", d[7:6], driver_limit_level)
      `CHK("limit off", d[5], driver_limit_off)
      aux_input_b_pin <= 1'($urandom);
      d = 8'($urandom);
      axw(ls_a, d, 4'hF);
      rdchk(ls_a, {aux_input_b_pin, 1'b0, d[5:0]});
      `CHK("filter", d[3], aux_input_b_glitch_filter_on)
      `CHK("threshold", d[2], aux_input_b_threshold_type)
      `CHK("source", d[1], aux_input_b_source_on)
      `CHK("sink", d[0], aux_input_b_sink_on)
    end
    // Every mix of control select, soft bits and pins
    aux_input_b_pin <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      b = 5'(i);
      axw(pc_a, {7'h00, b[4]}, 4'h1);
      axw(ls_a, {2'b00, b[3:2], 4'h0}, 4'h1);
      transmit_enable_pin_b <= b[1];
      transmit_data_pin_b <= b[0];
      // Pin changes need two sync stages, the output flop and two more stages for line level
      repeat (6) @(posedge aclk);
      en = b[4] ? b[3] : b[1];
      dt = b[4] ? b[2] : b[0];
      `CHK("tx enable", en, line_b_driver_enable)
      `CHK("tx data", dt, line_b_driver_data)
      rdchk(ls_a, {1'b0, en & dt, b[3:2], 4'h0});
    end
    // A write with no strobe leaves the register alone; level bits 7:6 take no write
    axw(lim_a, 8'hA5, 4'hF);
    axw(lim_a, 8'h5A, 4'h0);
    `CHK("no strobe resp", cq_cfg_pkg::resp_okay, rsp)
    axw(ls_a, 8'hC0, 4'h1);
    rdchk(lim_a, 8'hA5);
    rdchk(ls_a, 8'h00);
    axw(10'h3FC, 8'hFF, 4'hF);
    `CHK("unmapped write", cq_cfg_pkg::resp_slverr, rsp)
    axr(10'h3FC);
    `CHK("unmapped read", cq_cfg_pkg::resp_slverr, rsp)
    // Short on driver A: shortest blanking, no retry, so it latches off
    transmit_enable_pin_b <= 1'b0;
    axw(lim_a, 8'h00, 4'hF);
    short_a <= 1'b1;
    repeat (cq_cfg_pkg::blank0_cyc - 20) @(posedge aclk);
    `CHK("allow in blanking", 1'b1, line_a_driver_allow)
    n = 0;
    while (line_a_driver_allow === 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    `CHK("fault after blanking", 1'b1, n < 100)
    repeat (1000) @(posedge aclk);
    `CHK("latched off", 1'b0, line_a_driver_allow)
    rdchk({cq_cfg_pkg::drv_status_idx, 2'b00}, 8'h01);
    // Mid-run reset clears registers and fault flags and lets driver A on again
    short_a <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("allow after reset", 1'b1, line_a_driver_allow)
    rdchk(lim_a, cq_cfg_pkg::reset_byte);
    rdchk(ls_a, cq_cfg_pkg::reset_byte);
    rdchk({cq_cfg_pkg::drv_status_idx, 2'b00}, cq_cfg_pkg::reset_byte);
    give_verdict();
  end
endmodule
